// ---- lhife_top.sv ----
// LCD host interface front end: pin qualification, capture and steering.
`timescale 1ns/10ps
`default_nettype none
module lhife_top
  import lhife_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              reset_n_pin,
  input  wire logic              bus_width_select,
  input  wire logic              chip_select_low_active,
  input  wire logic              chip_select_high_active,
  input  wire logic              cpu_style_select,
  input  wire logic              read_enable_pin,
  input  wire logic              write_direction_pin,
  input  wire logic              data_command_select,
  input  wire logic [5:0]        data_low_in,
  output logic      [5:0]        data_low_out,
  output logic      [5:0]        data_low_oe,
  output logic      [5:0]        data_low_pulldown,
  input  wire logic              bit6_or_serial_clock_in,
  output logic                   bit6_or_serial_clock_out,
  output logic                   bit6_or_serial_clock_oe,
  input  wire logic              bit7_or_serial_input_in,
  output logic                   bit7_or_serial_input_out,
  output logic                   bit7_or_serial_input_oe,
  input  wire logic              clock_source_select,
  input  wire logic              display_clock_pin,
  input  wire logic              osc_clock,
  output logic                   osc_enable,
  output logic                   display_clock,
  output logic                   factory_test_output,
  input  wire logic [DATA_W-1:0] read_data,
  output logic                   read_taken,
  output logic      [DATA_W-1:0] rx_data,
  output logic                   rx_is_data,
  output logic                   rx_valid,
  input  wire logic              rx_ready,
  output logic                   parallel_mode,
  output logic                   internal_reset,
  output logic                   overrun
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Every pin but the display clock pin, the reset pin included, passes two flip-flops before use.
  // The reset pin thus acts two clocks late; a host holds it far longer than that.
  localparam int unsigned NSYNC = 17;
  logic [NSYNC-1:0] pins;
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;
  logic [NSYNC-1:0] s1_nxt;
  logic [NSYNC-1:0] s2_nxt;

  assign pins = {reset_n_pin, bus_width_select, chip_select_low_active,
                 chip_select_high_active, cpu_style_select, read_enable_pin,
                 write_direction_pin, data_command_select, bit7_or_serial_input_in,
                 bit6_or_serial_clock_in, data_low_in, clock_source_select};

  always_comb
  begin
    s1_nxt = pins;
    s2_nxt = s1_r;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      s1_r <= '0;
      s2_r <= '0;
    end
    else
    begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  logic       rst_pin_n;
  logic       width_s;
  logic       cs_n_s;
  logic       cs_s;
  logic       style_s;
  logic       rde_s;
  logic       wrd_s;
  logic       dc_s;
  logic [7:0] data_s;
  logic       cls_s;
  assign {rst_pin_n, width_s, cs_n_s, cs_s, style_s, rde_s, wrd_s, dc_s,
          data_s, cls_s} = s2_r;

  // ----------------------------------------------------------------
  // Mode latch, selection and strobe decode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LHIFE_BOOT   = 2'b00,
    LHIFE_STRAP  = 2'b01,
    LHIFE_RUN    = 2'b10
  } lhife_state_e;

  lhife_state_e state_r;
  lhife_state_e state_nxt;
  logic         par_r;
  logic         par_nxt;
  logic         ireset;
  logic         selected;
  logic         rd_active;
  logic         wr_active;
  logic         wr_act_r;
  logic         sclk_r;
  logic         wr_edge;
  logic         rd_edge;
  logic         rd_act_r;
  logic         sclk_rise;
  logic         run;

  assign ireset   = ~rst_pin_n;
  assign run      = (state_r == LHIFE_RUN);
  assign selected = ~cs_n_s & cs_s;

  // 68 style: enable high frames a transfer, direction picks read or write.
  always_comb
  begin
    if (style_s)
    begin
      rd_active = selected & rde_s & wrd_s;
      wr_active = selected & rde_s & ~wrd_s;
    end
    else
    begin
      rd_active = selected & ~rde_s;
      wr_active = selected & ~wrd_s;
    end
  end

  // A deselect with the strobe still active also ends a write, because hosts
  // often release select and strobe together and both arrive in one cycle.
  // Capture on the trailing edge: 80-style write rising, 68-style enable falling.
  assign wr_edge   = wr_act_r & ~wr_active & run & par_r;
  assign rd_edge   = rd_act_r & ~rd_active & run & par_r;
  assign sclk_rise = data_s[6] & ~sclk_r & run & ~par_r & selected;

  // The strap is caught once, after the internal reset releases, then frozen.
  always_comb
  begin
    state_nxt = state_r;
    par_nxt   = par_r;
    unique case (state_r)
      LHIFE_BOOT:  state_nxt = ireset ? LHIFE_BOOT : LHIFE_STRAP;
      LHIFE_STRAP:
      begin
        par_nxt   = width_s;
        state_nxt = LHIFE_RUN;
      end
      LHIFE_RUN:   state_nxt = LHIFE_RUN;
      // Code 2'b11 is never entered; should it appear, the block boots again.
      default:     state_nxt = LHIFE_BOOT;
    endcase
  end

  // ----------------------------------------------------------------
  // Serial shifter and FIFO feed
  // ----------------------------------------------------------------
  logic [7:0]           shift_r;
  logic [7:0]           shift_nxt;
  logic [BIT_CNT_W-1:0] cnt_r;
  logic [BIT_CNT_W-1:0] cnt_nxt;
  logic                 ser_done;
  logic [WORD_W-1:0]    f_in;
  logic                 f_valid;
  logic                 f_ready;
  logic                 ovr_r;
  logic                 ovr_nxt;

  always_comb
  begin
    // The count restarts on every deselect, so a cut frame never joins the next.
    shift_nxt = shift_r;
    cnt_nxt   = cnt_r;
    ser_done  = 1'b0;
    if (!selected || par_r)
    begin
      cnt_nxt = BIT_CNT_RST;
    end
    else if (sclk_rise)
    begin
      shift_nxt = {shift_r[6:0], data_s[7]};
      cnt_nxt   = cnt_r + 1'b1;
      ser_done  = (cnt_r == BIT_CNT_LAST);
    end
  end

  // A byte that meets a full FIFO is dropped and flagged; the host has no wait pin.
  // The flag stays set until a reset, so no lost byte goes unnoticed.
  always_comb
  begin
    f_valid = wr_edge | ser_done;
    f_in    = {dc_s, (par_r ? data_s : shift_nxt)};
    ovr_nxt = ovr_r | (f_valid & ~f_ready);
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_r  <= LHIFE_BOOT;
      par_r    <= 1'b1;
      wr_act_r <= 1'b0;
      rd_act_r <= 1'b0;
      sclk_r   <= 1'b0;
      shift_r  <= SHIFT_RST;
      cnt_r    <= BIT_CNT_RST;
      ovr_r    <= 1'b0;
    end
    // The pin reset clears control state but leaves queued bytes in the FIFO.
    else if (ireset)
    begin
      state_r  <= LHIFE_BOOT;
      par_r    <= 1'b1;
      wr_act_r <= 1'b0;
      rd_act_r <= 1'b0;
      sclk_r   <= 1'b0;
      shift_r  <= SHIFT_RST;
      cnt_r    <= BIT_CNT_RST;
      ovr_r    <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      par_r    <= par_nxt;
      wr_act_r <= wr_active;
      rd_act_r <= rd_active;
      sclk_r   <= data_s[6];
      shift_r  <= shift_nxt;
      cnt_r    <= cnt_nxt;
      ovr_r    <= ovr_nxt;
    end
  end

  // The data/command bit rides above the byte, so both leave the FIFO together.
  lhife_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .reset     (reset),
    .in_data   (f_in),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .out_data  ({rx_is_data, rx_data}),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  // ----------------------------------------------------------------
  // Read path and pin drive
  // ----------------------------------------------------------------
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       oe_r;
  logic       oe_nxt;

  always_comb
  begin
    // Read data is frozen while a read runs, so the pins never change mid-read.
    rdata_nxt = rd_active ? rdata_r : read_data;
    oe_nxt    = rd_active & par_r & run;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      rdata_r <= RDATA_RST;
      oe_r    <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      oe_r    <= oe_nxt;
    end
  end

  // Serial mode drives no pin; the two upper pins then carry clock and data in.
  assign read_taken               = rd_edge;
  assign data_low_out             = rdata_r[5:0];
  assign data_low_oe              = {6{oe_r}};
  assign data_low_pulldown        = par_r ? PULL_DOWN : ~PULL_DOWN;
  assign bit6_or_serial_clock_out = rdata_r[6];
  assign bit6_or_serial_clock_oe  = oe_r & par_r;
  assign bit7_or_serial_input_out = rdata_r[7];
  assign bit7_or_serial_input_oe  = oe_r & par_r;

  // Clock steering is a plain mux; a glitch-free switch is not needed as the pin is static.
  assign osc_enable          = cls_s;
  assign display_clock       = cls_s ? osc_clock : display_clock_pin;
  // The display clock pin is only an input here; its output drive belongs to the
  // timing generator, which sits outside this block.
  assign factory_test_output = 1'b0;
  assign parallel_mode       = par_r;
  assign internal_reset      = ireset | ~run;
  assign overrun             = ovr_r;
endmodule
`default_nettype wire

// ---- lhife_pkg.sv ----
// Constants shared by the LCD host interface front end.
package lhife_pkg;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam int unsigned WORD_W       = DATA_W + 1;
  localparam int unsigned BIT_CNT_W    = 3;
  localparam logic [2:0]  BIT_CNT_RST  = 3'h0;
  localparam logic [2:0]  BIT_CNT_LAST = 3'h7;
  localparam logic [7:0]  SHIFT_RST    = 8'h00;
  localparam logic [7:0]  RDATA_RST    = 8'h00;
  localparam logic [5:0]  PULL_DOWN    = 6'h00;
endpackage

// ---- lhife_fifo.sv ----
// Small flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module lhife_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    wr_ptr_nxt;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW-1:0]    rd_ptr_nxt;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    wr_ptr_nxt = push ? AW'((wr_ptr_r + 1'b1) % DEPTH) : wr_ptr_r;
    rd_ptr_nxt = pop ? AW'((rd_ptr_r + 1'b1) % DEPTH) : rd_ptr_r;
    count_nxt  = count_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
    end
  end

  // Storage carries no reset; the pointers and the count alone decide what is valid.
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ---- lhife_checker.sv ----
// Concurrent checks on the ports of the LCD host interface front end.
`timescale 1ns/10ps
`default_nettype none
module lhife_checker (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       cpu_style_select,
  input wire logic       read_enable_pin,
  input wire logic       chip_select_low_active,
  input wire logic       chip_select_high_active,
  input wire logic       clock_source_select,
  input wire logic       display_clock_pin,
  input wire logic       osc_clock,
  input wire logic       osc_enable,
  input wire logic       display_clock,
  input wire logic [5:0] data_low_oe,
  input wire logic [5:0] data_low_pulldown,
  input wire logic       rx_is_data,
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic       parallel_mode,
  input wire logic       internal_reset
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire logic sel = !chip_select_low_active && chip_select_high_active;
  // Six cycles cover the pin synchronisers and the three-clock drive lag.
  sequence s_rd80_on;
    (parallel_mode && !cpu_style_select && sel && !read_enable_pin && !internal_reset) [*6];
  endsequence
  sequence s_rd80_off;
    (!cpu_style_select && read_enable_pin && !internal_reset) [*6];
  endsequence
  sequence s_src_quiet;
    ($stable(clock_source_select) && !internal_reset) [*4];
  endsequence
  a_read_drive: assert property (s_rd80_on |-> data_low_oe == 6'h3F)
    else $error("Bus not driven during read");
  a_read_quiet: assert property (s_rd80_off |-> data_low_oe == 6'h00)
    else $error("Bus driven without read");
  a_serial_no_drive: assert property (!parallel_mode |-> data_low_oe == 6'h00)
    else $error("Low data pins driven in serial mode");
  a_pulldown_mode: assert property (data_low_pulldown == {6{!parallel_mode}})
    else $error("Pull-down state disagrees with mode");
  a_mode_fixed: assert property (!internal_reset && !$past(internal_reset) |->
    $stable(parallel_mode)) else $error("Interface mode changed while running");
  a_osc_follow: assert property (s_src_quiet |-> osc_enable == clock_source_select)
    else $error("Oscillator enable does not follow source select");
  a_clk_mux: assert property (display_clock == (osc_enable ? osc_clock : display_clock_pin))
    else $error("Display clock from wrong source");
  a_rx_hold: assert property (rx_valid && !rx_ready |=>
    rx_valid && $stable({rx_is_data, rx_data}))
    else $error("Received byte dropped before it was taken");
endmodule
bind lhife_top lhife_checker chk (.*);
`default_nettype wire

// ---- lhife_host.sv ----
// Host processor model driving the select, strobe and data pins.
`timescale 1ns/10ps
`default_nettype none
module lhife_host (
  input  wire logic       clock,
  input  wire logic       style68,
  input  wire logic [7:0] din,
  output logic            cs_n,
  output logic            cs,
  output logic            rd,
  output logic            wr,
  output logic            a0,
  output logic [7:0]      bus,
  output logic            drv
);
  initial
  begin
    {cs_n, cs, rd, wr, a0, bus, drv} = {5'h1E, 8'h00, 1'b0};
  end
  task automatic style(input logic s);
    rd = !s;
    wr = 1'b1;
  endtask
  // Every level is held at least three clocks because the device synchronises each pin.
  task automatic xfer(input logic wrt, input logic dc, input logic [7:0] d,
                      input logic [1:0] s, output logic [7:0] got);
    @(negedge clock);
    {cs_n, cs} = s;
    {a0, bus, drv} = {dc, d, wrt};
    if (style68)
      wr = !wrt;
    repeat (3) @(negedge clock);
    if (style68)
      rd = 1'b1;
    else if (wrt)
      wr = 1'b0;
    else
      rd = 1'b0;
    repeat (6) @(negedge clock);
    got = din;
    rd = !style68;
    if (!style68)
      wr = 1'b1;
    repeat (3) @(negedge clock);
    {cs_n, cs, wr, drv, bus} = {3'b101, 1'b0, ~d};
    repeat (2) @(negedge clock);
  endtask
  // The serial clock stands low between frames; the data line turns over once released.
  task automatic sbits(input logic [7:0] d, input int n, input logic dc);
    @(negedge clock);
    {cs_n, cs, a0, bus[6]} = {2'b01, dc, 1'b0};
    for (int i = 7; i > 7 - n; i--)
    begin
      bus[7] = d[i];
      repeat (3) @(negedge clock);
      bus[6] = 1'b1;
      repeat (3) @(negedge clock);
      bus[6] = 1'b0;
    end
    repeat (3) @(negedge clock);
    {cs_n, cs, bus[7]} = {2'b10, ~bus[7]};
    repeat (3) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// ---- lhife_top_tb.sv ----
// Self-checking testbench for the LCD host interface front end.
`timescale 1ns/10ps
`default_nettype none
module lhife_top_tb;
  import lhife_pkg::*;
  logic       clock, reset, reset_n_pin, bus_width_select, cpu_style_select, read_enable_pin;
  logic       chip_select_low_active, chip_select_high_active, write_direction_pin, drv;
  logic       data_command_select, bit6_or_serial_clock_in, bit6_or_serial_clock_out, a;
  logic       bit6_or_serial_clock_oe, bit7_or_serial_input_in, bit7_or_serial_input_out;
  logic       bit7_or_serial_input_oe, clock_source_select, display_clock_pin, osc_clock;
  logic       osc_enable, display_clock, factory_test_output, read_taken, rx_is_data;
  logic       rx_valid, rx_ready, parallel_mode, internal_reset, overrun;
  logic [5:0] data_low_in, data_low_out, data_low_oe, data_low_pulldown;
  logic [7:0] read_data, rx_data, bus, got, v;
  logic [8:0] expq[$];
  int         n_mismatch, n_compared, cyc, n_reads;
  lhife_top uut (.*);
  lhife_host host (.clock(clock), .style68(cpu_style_select), .din({bit7_or_serial_input_in,
    bit6_or_serial_clock_in, data_low_in}), .cs_n(chip_select_low_active),
    .cs(chip_select_high_active), .rd(read_enable_pin), .wr(write_direction_pin),
    .a0(data_command_select), .bus(bus), .drv(drv));
  // A released low pin reads its pull-down only while the device enables it.
  assign data_low_in = (data_low_oe & data_low_out)
    | (~data_low_oe & ~(data_low_pulldown & {6{~drv}}) & bus[5:0]);
  assign bit6_or_serial_clock_in = bit6_or_serial_clock_oe ? bit6_or_serial_clock_out : bus[6];
  assign bit7_or_serial_input_in = bit7_or_serial_input_oe ? bit7_or_serial_input_out : bus[7];
  initial
    forever #4 clock = ~clock;
  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic put(input logic [1:0] s, input logic keep);
    v = 8'($urandom);
    a = 1'($urandom);
    if (keep)
      expq.push_back({a, v});
    host.xfer(1'b1, a, v, s, got);
  endtask
  always @(posedge clock)
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      chk({rx_is_data, rx_data}, (expq.size() > 0) ? expq.pop_front() : 9'bx);
  always @(negedge clock)
    if (read_taken === 1'b1)
      n_reads++;
  always @(negedge clock)
  begin
    osc_clock <= ~osc_clock;
    display_clock_pin <= osc_clock;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  initial
  begin
    {clock, reset, reset_n_pin, bus_width_select, cpu_style_select} = 5'h0E;
    {clock_source_select, osc_clock, display_clock_pin, rx_ready, read_data} = 12'h900;
    void'($urandom(32));
    repeat (3) @(posedge clock);
    @(negedge clock) reset = 1'b0;
    repeat (8) @(negedge clock);
    chk({8'h00, parallel_mode}, 9'h001);
    chk({8'h00, factory_test_output}, 9'h000);
    for (int s = 0; s < 2; s++)
    begin
      cpu_style_select = s[0];
      host.style(s[0]);
      for (int i = 0; i < 3; i++)
        put(2'b01, 1'b1);
      put(2'b11, 1'b0);
      put(2'b00, 1'b0);
      read_data = 8'($urandom);
      host.xfer(1'b0, 1'b1, 8'h00, 2'b01, got);
      chk({1'b0, got}, {1'b0, read_data});
    end
    {rx_ready, clock_source_select} = 2'b00;
    for (int i = 0; i < 9; i++)
      put(2'b01, i < FIFO_DEPTH);
    repeat (4) @(negedge clock);
    chk({8'h00, overrun}, 9'h001);
    {rx_ready, bus_width_select} = 2'b10;
    repeat (20) @(negedge clock);
    chk({8'h00, parallel_mode}, 9'h001);
    reset_n_pin = 1'b0;
    repeat (4) @(negedge clock);
    chk({8'h00, internal_reset}, 9'h001);
    reset_n_pin = 1'b1;
    repeat (10) @(negedge clock);
    chk({~parallel_mode, 2'b00, data_low_pulldown}, 9'h13F);
    host.sbits(8'hFF, 5, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($urandom);
      expq.push_back({v[0], v});
      host.sbits(v, 8, v[0]);
    end
    repeat (10) @(negedge clock);
    chk(9'(expq.size()), 9'h000);
    chk(9'(n_reads), 9'h002);
    stop_test();
  end
endmodule
`default_nettype wire
